//--- rtl/metering_interrupt_mask_one.sv
`timescale 1ns/1ps
module metering_interrupt_mask_one
    import metering_mask_pkg::*;
(
    // Clock and reset
    input  wire logic                hclk,
    input  wire logic                hresetn,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    // Idle levels per phase
    input  wire logic [2:0]          idle_total,
    input  wire logic [2:0]          idle_fund,
    input  wire logic [2:0]          idle_app,
    // Zero crossing events per phase
    input  wire logic [2:0]          volt_timeout_evt,
    input  wire logic [2:0]          curr_timeout_evt,
    input  wire logic [2:0]          volt_cross_evt,
    input  wire logic [2:0]          curr_cross_evt,
    input  wire logic [2:0]          volt_rise_evt,
    // Fault events per phase
    input  wire logic [2:0]          dip_evt,
    input  wire logic [2:0]          overcurrent_evt,
    input  wire logic [2:0]          high_voltage_evt,
    // Other events
    input  wire logic                reset_complete_event,
    input  wire logic                curr_peak_end_evt,
    input  wire logic                volt_peak_end_evt,
    // Neutral check samples
    input  wire logic [WAVE_W-1:0]   phase_current_sum,
    input  wire logic [WAVE_W-1:0]   neutral_current_sample,
    // Checksum
    input  wire logic [31:0]         checksum,
    input  wire logic                run_set,
    // Interrupt request
    output logic                     irq
);

    // -----------------------------------------------------------------
    // Storage
    // -----------------------------------------------------------------
    logic [31:0]       interrupt_enable_mask_one;
    logic [31:0]       event_status_one;
    logic [15:0]       per_phase_status_register;
    logic [8:0]        per_phase_idle_flags;
    logic [WAVE_W-1:0] imbalance_threshold;
    logic [31:0]       wr_addr;
    logic              wr_pend;
    logic [8:0]        idle_prev;
    logic              imbal_prev;
    logic              crc_prev;
    logic              crc_armed;
    logic [31:0]       crc_snap;
    order_state_e      order_state;
    logic [31:0]       set_vec;
    logic [31:0]       clr_vec;
    logic [31:0]       next_status;
    logic [31:0]       rd_mux;
    logic              order_err;
    logic              imbal_now;
    logic              crc_diff;
    logic [WAVE_W-1:0] mag_sum;
    logic [WAVE_W-1:0] mag_neu;
    logic [WAVE_W-1:0] mag_gap;

    // Magnitude of a two's complement sample
    function automatic logic [WAVE_W-1:0] magnitude(input logic [WAVE_W-1:0] v);
        magnitude = v[WAVE_W-1] ? WAVE_W'(~v + 1'b1) : v;
    endfunction

    // -----------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY
    // -----------------------------------------------------------------
    wire addr_ok = hsel && htrans[1] && hready;

    // Capture write address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 32'h0000_0000;
        end
        else
        begin
            wr_pend <= addr_ok && hwrite;
            if (addr_ok && hwrite)
                wr_addr <= haddr;
        end
    end

    // Read mux, unmapped addresses read zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (haddr == MASK_ADDR)
            rd_mux = interrupt_enable_mask_one;
        else if (haddr == STATUS_ADDR)
            rd_mux = event_status_one;
        else if (haddr == PHASE_ADDR)
            rd_mux = {16'h0000, per_phase_status_register};
        else if (haddr == IDLE_ADDR)
            rd_mux = {23'h000000, per_phase_idle_flags};
        else if (haddr == THRESH_ADDR)
            rd_mux = {4'h0, imbalance_threshold};
    end

    // Read data is latched at the address phase so it stands in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_ok && !hwrite)
                hrdata <= rd_mux;
        end
    end

    // -----------------------------------------------------------------
    // Software registers
    // -----------------------------------------------------------------
    // Reserved mask bits never store, so they read zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            interrupt_enable_mask_one <= MASK_RESET;
        else if (wr_pend && wr_addr == MASK_ADDR)
            interrupt_enable_mask_one <= hwdata & MASK_WRITE;
    end

    // Mismatch threshold
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            imbalance_threshold <= THRESH_RESET;
        else if (wr_pend && wr_addr == THRESH_ADDR)
            imbalance_threshold <= hwdata[WAVE_W-1:0];
    end

    // -----------------------------------------------------------------
    // Event sources
    // -----------------------------------------------------------------
    // Idle levels, delayed for entry detection
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            idle_prev            <= 9'h000;
            per_phase_idle_flags <= 9'h000;
        end
        else
        begin
            idle_prev            <= {idle_app, idle_fund, idle_total};
            per_phase_idle_flags <= {idle_app, idle_fund, idle_total};
        end
    end

    // Phase order: A rising, then C rising before B is an error
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            order_state <= ORDER_IDLE;
        else
        begin
            case (order_state)
                ORDER_IDLE:
                    if (volt_rise_evt[0])
                        order_state <= ORDER_ARMED;
                ORDER_ARMED:
                    if (volt_rise_evt[1] || volt_rise_evt[2])
                        order_state <= volt_rise_evt[0] ? ORDER_ARMED : ORDER_IDLE;
                default:
                    order_state <= ORDER_IDLE;
            endcase
        end
    end

    // B wins a tie with C: only a clean C rise counts as wrong order
    assign order_err = (order_state == ORDER_ARMED)
                       && volt_rise_evt[2] && !volt_rise_evt[1];

    // Neutral mismatch magnitude
    always_comb
    begin
        mag_sum = magnitude(phase_current_sum);
        mag_neu = magnitude(neutral_current_sample);
        mag_gap = (mag_sum > mag_neu) ? mag_sum - mag_neu : mag_neu - mag_sum;
    end
    assign imbal_now = mag_gap > imbalance_threshold;

    // Checksum snapshot taken when run is set
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            crc_snap  <= 32'h0000_0000;
            crc_armed <= 1'b0;
        end
        else if (run_set)
        begin
            crc_snap  <= checksum;
            crc_armed <= 1'b1;
        end
    end
    assign crc_diff = crc_armed && !run_set && (checksum != crc_snap);

    // Level conditions become single events on their rising edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            imbal_prev <= 1'b0;
            crc_prev   <= 1'b0;
        end
        else
        begin
            imbal_prev <= imbal_now;
            crc_prev   <= crc_diff;
        end
    end

    // -----------------------------------------------------------------
    // Sticky status, set wins over write-one-to-clear
    // -----------------------------------------------------------------
    always_comb
    begin
        set_vec = 32'h0000_0000;
        set_vec[B_IDLE_TOT]              = |(idle_total & ~idle_prev[2:0]);
        set_vec[B_IDLE_FUND]             = |(idle_fund & ~idle_prev[5:3]);
        set_vec[B_IDLE_APP]              = |(idle_app & ~idle_prev[8:6]);
        set_vec[B_VTO+2:B_VTO]           = volt_timeout_evt;
        set_vec[B_CTO+2:B_CTO]           = curr_timeout_evt;
        set_vec[B_VZX+2:B_VZX]           = volt_cross_evt;
        set_vec[B_CZX+2:B_CZX]           = curr_cross_evt;
        set_vec[B_RST_DONE]              = reset_complete_event;
        set_vec[B_DIP]                   = |dip_evt;
        set_vec[B_OVERCUR]               = |overcurrent_evt;
        set_vec[B_HIGH_VOLT]             = |high_voltage_evt;
        set_vec[B_ORDER]                 = order_err;
        set_vec[B_IMBAL]                 = imbal_now && !imbal_prev;
        set_vec[B_PEAK_CURR]             = curr_peak_end_evt;
        set_vec[B_PEAK_VOLT]             = volt_peak_end_evt;
        set_vec[B_CHECKSUM]              = crc_diff && !crc_prev;
        clr_vec = (wr_pend && wr_addr == STATUS_ADDR) ? hwdata : 32'h0000_0000;
        next_status = (event_status_one & ~clr_vec) | set_vec;
    end

    // Status ignores the mask entirely
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            event_status_one <= STATUS_RESET;
        else
            event_status_one <= next_status;
    end

    // Phase flags follow their summary bit; cleared with it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            per_phase_status_register <= PHASE_RESET;
        else
        begin
            if (clr_vec[B_OVERCUR])
                per_phase_status_register[P_OVERCUR+2:P_OVERCUR] <= 3'h0;
            if (clr_vec[B_HIGH_VOLT])
                per_phase_status_register[P_HIGH_VOLT+2:P_HIGH_VOLT] <= 3'h0;
            if (clr_vec[B_DIP])
                per_phase_status_register[P_DIP+2:P_DIP] <= 3'h0;
            if (|overcurrent_evt)
                per_phase_status_register[P_OVERCUR+2:P_OVERCUR] <=
                    per_phase_status_register[P_OVERCUR+2:P_OVERCUR]
                    & ~{3{clr_vec[B_OVERCUR]}} | overcurrent_evt;
            if (|high_voltage_evt)
                per_phase_status_register[P_HIGH_VOLT+2:P_HIGH_VOLT] <=
                    per_phase_status_register[P_HIGH_VOLT+2:P_HIGH_VOLT]
                    & ~{3{clr_vec[B_HIGH_VOLT]}} | high_voltage_evt;
            if (|dip_evt)
                per_phase_status_register[P_DIP+2:P_DIP] <=
                    per_phase_status_register[P_DIP+2:P_DIP]
                    & ~{3{clr_vec[B_DIP]}} | dip_evt;
        end
    end

    // -----------------------------------------------------------------
    // Interrupt request: one cycle behind status, reset-done unmaskable
    // -----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq <= 1'b0;
        else
            irq <= |(event_status_one & interrupt_enable_mask_one & ~(32'h1 << B_RST_DONE))
                   || event_status_one[B_RST_DONE];
    end

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence mask_write_s;
        wr_pend && wr_addr == MASK_ADDR;
    endsequence

    mask_store_a: assert property (mask_write_s |=>
        interrupt_enable_mask_one == ($past(hwdata) & MASK_WRITE))
        else $error("mask register did not store write");
    reserved_zero_a: assert property ((interrupt_enable_mask_one & ~MASK_WRITE) == 0)
        else $error("reserved mask bit is set");
    irq_raise_a: assert property (
        |(event_status_one & interrupt_enable_mask_one) |=> irq)
        else $error("enabled status did not raise irq");
    irq_drop_a: assert property (
        (event_status_one & interrupt_enable_mask_one) == 0
        && !event_status_one[B_RST_DONE] |=> !irq)
        else $error("irq high with nothing enabled");
    rst_done_irq_a: assert property (reset_complete_event |=> ##1 irq)
        else $error("reset complete not delivered");
    idle_sets_a: assert property (
        (|(idle_total & ~idle_prev[2:0])) |=> event_status_one[B_IDLE_TOT])
        else $error("idle entry did not set status");

    // A rise, one quiet cycle, then a lone C rise: fixed spacing, no open window
    sequence a_then_c_s;
        volt_rise_evt == 3'b001 ##1 volt_rise_evt == 3'b000
        ##1 volt_rise_evt == 3'b100;
    endsequence

    order_err_a: assert property (a_then_c_s |=> event_status_one[B_ORDER])
        else $error("phase order error not flagged");
    overcur_phase_a: assert property (overcurrent_evt[0] |=>
        per_phase_status_register[P_OVERCUR] && event_status_one[B_OVERCUR])
        else $error("overcurrent phase A not recorded");
    imbal_flag_a: assert property ($rose(imbal_now) |=> event_status_one[B_IMBAL])
        else $error("neutral mismatch not flagged");
    crc_flag_a: assert property ($rose(crc_diff) |=> event_status_one[B_CHECKSUM])
        else $error("checksum change not flagged");

endmodule

//--- rtl/metering_mask_pkg.sv
// Operation
// - Mask register at index e50b, resets zero
// - Bit 0 enables total-power idle interrupt
// - Bit 1 enables fundamental-power idle interrupt
// - Bit 2 enables apparent-power idle interrupt
// - Bits 3-5 enable missing voltage crossing
// - Bits 6-8 enable missing current crossing
// - Bits 9-11 enable voltage crossing seen
// - Bits 12-14 enable current crossing seen
// - Bit 15 inert; reset-done always interrupts
// - Bit 16 enables dip; phases in 14:12
// - Bit 17 enables overcurrent; phases in 5:3
// - Bit 18 enables overvoltage; phases in 11:9
// - Bit 19 enables A-then-C order error
// - Bit 20 enables sum-neutral mismatch interrupt
// - Bits 22:21 and 31:26 reserved zero
// - Bit 23 enables current peak window end
// - Bit 24 enables voltage peak window end
// - Bit 25 enables checksum change interrupt
// - Phase flags 5:3 name overcurrent phases
// - Per-phase idle flags set with summary
package metering_mask_pkg;

    // -----------------------------------------------------------------
    // Register indices and byte addresses (byte address = 4 * index)
    // -----------------------------------------------------------------
    localparam logic [15:0] MASK_IDX    = 16'he50b;
    localparam logic [15:0] STATUS_IDX  = 16'he502;
    localparam logic [15:0] PHASE_IDX   = 16'he600;
    localparam logic [15:0] IDLE_IDX    = 16'he608;
    localparam logic [15:0] THRESH_IDX  = 16'he5f0;
    localparam logic [31:0] MASK_ADDR   = {14'h0000, MASK_IDX, 2'b00};
    localparam logic [31:0] STATUS_ADDR = {14'h0000, STATUS_IDX, 2'b00};
    localparam logic [31:0] PHASE_ADDR  = {14'h0000, PHASE_IDX, 2'b00};
    localparam logic [31:0] IDLE_ADDR   = {14'h0000, IDLE_IDX, 2'b00};
    localparam logic [31:0] THRESH_ADDR = {14'h0000, THRESH_IDX, 2'b00};

    // -----------------------------------------------------------------
    // Reset values and writable bits
    // -----------------------------------------------------------------
    localparam logic [31:0] MASK_RESET   = 32'h0000_0000;
    localparam logic [31:0] MASK_WRITE   = 32'h039f_ffff;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [15:0] PHASE_RESET  = 16'h0000;
    localparam logic [27:0] THRESH_RESET = 28'h000_0000;

    // -----------------------------------------------------------------
    // Bit positions in mask and status
    // -----------------------------------------------------------------
    localparam int B_IDLE_TOT  = 0;
    localparam int B_IDLE_FUND = 1;
    localparam int B_IDLE_APP  = 2;
    localparam int B_VTO       = 3;
    localparam int B_CTO       = 6;
    localparam int B_VZX       = 9;
    localparam int B_CZX       = 12;
    localparam int B_RST_DONE  = 15;
    localparam int B_DIP       = 16;
    localparam int B_OVERCUR   = 17;
    localparam int B_HIGH_VOLT = 18;
    localparam int B_ORDER     = 19;
    localparam int B_IMBAL     = 20;
    localparam int B_PEAK_CURR = 23;
    localparam int B_PEAK_VOLT = 24;
    localparam int B_CHECKSUM  = 25;

    // Phase-status field positions
    localparam int P_OVERCUR   = 3;
    localparam int P_HIGH_VOLT = 9;
    localparam int P_DIP       = 12;

    // Waveform sample width
    localparam int WAVE_W = 28;

    // Phase order checker states
    typedef enum logic [1:0] {
        ORDER_IDLE  = 2'b01,
        ORDER_ARMED = 2'b10
    } order_state_e;

endpackage

//--- sim/metering_interrupt_mask_one_test.sv
`timescale 1ns/1ps
module metering_interrupt_mask_one_test;
    import metering_mask_pkg::*;

    // ------------------------------------------------------------------
    // Design ports
    // ------------------------------------------------------------------
    logic              hclk;
    logic              hresetn;
    logic              hsel;
    logic [31:0]       haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [31:0]       hwdata;
    logic [31:0]       hrdata;
    logic              hreadyout;
    logic              hresp;
    logic [2:0]        idle_total;
    logic [2:0]        idle_fund;
    logic [2:0]        idle_app;
    logic [2:0]        volt_timeout_evt;
    logic [2:0]        curr_timeout_evt;
    logic [2:0]        volt_cross_evt;
    logic [2:0]        curr_cross_evt;
    logic [2:0]        volt_rise_evt;
    logic [2:0]        dip_evt;
    logic [2:0]        overcurrent_evt;
    logic [2:0]        high_voltage_evt;
    logic              reset_complete_event;
    logic              curr_peak_end_evt;
    logic              volt_peak_end_evt;
    logic [WAVE_W-1:0] phase_current_sum;
    logic [WAVE_W-1:0] neutral_current_sample;
    logic [31:0]       checksum;
    logic              run_set;
    logic              irq;
    int                fail_count;
    int                check_count;
    int                cycle_count;

    // ------------------------------------------------------------------
    // Clock, time-zero values and the design
    // ------------------------------------------------------------------
    // The single slave's ready is the bus ready
    always #4 hclk = ~hclk;
    initial
    begin
        {hclk, hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
        hsize = 3'h2;
        {idle_total, idle_fund, idle_app, volt_timeout_evt, curr_timeout_evt} = '0;
        {volt_cross_evt, curr_cross_evt, volt_rise_evt, dip_evt} = '0;
        {overcurrent_evt, high_voltage_evt, reset_complete_event} = '0;
        {curr_peak_end_evt, volt_peak_end_evt, run_set} = '0;
        {phase_current_sum, neutral_current_sample, checksum} = '0;
    end

    metering_interrupt_mask_one u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .idle_total(idle_total), .idle_fund(idle_fund), .idle_app(idle_app),
        .volt_timeout_evt(volt_timeout_evt), .curr_timeout_evt(curr_timeout_evt),
        .volt_cross_evt(volt_cross_evt), .curr_cross_evt(curr_cross_evt),
        .volt_rise_evt(volt_rise_evt), .dip_evt(dip_evt),
        .overcurrent_evt(overcurrent_evt), .high_voltage_evt(high_voltage_evt),
        .reset_complete_event(reset_complete_event), .curr_peak_end_evt(curr_peak_end_evt),
        .volt_peak_end_evt(volt_peak_end_evt), .phase_current_sum(phase_current_sum),
        .neutral_current_sample(neutral_current_sample), .checksum(checksum),
        .run_set(run_set), .irq(irq));

    // ------------------------------------------------------------------
    // Reporting and bus tasks
    // ------------------------------------------------------------------
    task end_sim;
        if (fail_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task chk_bit(input string n, input logic e, input logic g);
        chk_word(n, {31'h0, e}, {31'h0, g});
    endtask

    // Address phase held until ready is seen at a rising edge
    task addr_phase(input logic [31:0] a, input logic w);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
    endtask

    task bus_write(input logic [31:0] a, input logic [31:0] d);
        addr_phase(a, 1'b1);
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask

    task check_reg(input string n, input logic [31:0] a, input logic [31:0] e);
        addr_phase(a, 1'b0);
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        chk_word(n, e, hrdata);
        chk_bit("hresp", 1'b0, hresp);
    endtask

    // Let the edge's register updates land before looking
    task settle(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    // Drives the event source that belongs to one mask bit
    task drive(input int b, input logic v);
        case (b)
            0: idle_total[0] <= v;
            1: idle_fund[0] <= v;
            2: idle_app[0] <= v;
            3, 4, 5: volt_timeout_evt[b-3] <= v;
            6, 7, 8: curr_timeout_evt[b-6] <= v;
            9, 10, 11: volt_cross_evt[b-9] <= v;
            12, 13, 14: curr_cross_evt[b-12] <= v;
            15: reset_complete_event <= v;
            16: dip_evt[0] <= v;
            17: overcurrent_evt[0] <= v;
            18: high_voltage_evt[0] <= v;
            23: curr_peak_end_evt <= v;
            default: volt_peak_end_evt <= v;
        endcase
    endtask

    task pulse(input int b);
        @(posedge hclk);
        drive(b, 1'b1);
        @(posedge hclk);
        drive(b, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Reserved bits must drop even when software writes all ones
    task t_mask_rw;
        check_reg("mask reset", MASK_ADDR, 32'h0000_0000);
        check_reg("status reset", STATUS_ADDR, 32'h0000_0000);
        bus_write(MASK_ADDR, 32'hffff_ffff);
        check_reg("mask ones", MASK_ADDR, 32'h039f_ffff);
        bus_write(32'h0000_0100, 32'hffff_ffff);
        check_reg("unmapped", 32'h0000_0100, 32'h0000_0000);
        bus_write(MASK_ADDR, 32'h0000_0000);
        check_reg("mask zero", MASK_ADDR, 32'h0000_0000);
    endtask

    // Each enable bit but 15, 19, 20 and 25 first masked, then enabled, then cleared
    task t_events;
        for (int b = 0; b < 25; b++)
        begin
            if (!(b inside {15, 19, 20, 21, 22}))
            begin
                pulse(b);
                settle(3);
                chk_bit("irq masked", 1'b0, irq);
                check_reg("status masked", STATUS_ADDR, 32'h1 << b);
                bus_write(STATUS_ADDR, 32'h1 << b);
                bus_write(MASK_ADDR, 32'h1 << b);
                pulse(b);
                settle(3);
                chk_bit("irq enabled", 1'b1, irq);
                bus_write(STATUS_ADDR, 32'h1 << b);
                settle(2);
                chk_bit("irq cleared", 1'b0, irq);
                bus_write(MASK_ADDR, 32'h0000_0000);
            end
        end
    endtask

    // Reset-done interrupts with the mask all zero
    task t_rst_done;
        pulse(15);
        settle(3);
        chk_bit("reset done irq", 1'b1, irq);
        bus_write(STATUS_ADDR, 32'h0000_8000);
        settle(2);
        chk_bit("reset done clear", 1'b0, irq);
    endtask

    // Phase flags for three faults on three different phases
    task t_phase;
        @(posedge hclk);
        overcurrent_evt <= 3'b010;
        dip_evt <= 3'b100;
        high_voltage_evt <= 3'b001;
        @(posedge hclk);
        {overcurrent_evt, dip_evt, high_voltage_evt} <= '0;
        settle(2);
        check_reg("phase flags", PHASE_ADDR, 32'h0000_4210);
        check_reg("fault status", STATUS_ADDR, 32'h0007_0000);
        bus_write(STATUS_ADDR, 32'h0007_0000);
        check_reg("phase cleared", PHASE_ADDR, 32'h0000_0000);
    endtask

    // Two phases go idle together; summary and per-phase flags agree
    task t_idle;
        @(posedge hclk);
        idle_total <= 3'b110;
        settle(3);
        check_reg("idle flags", IDLE_ADDR, 32'h0000_0006);
        check_reg("idle status", STATUS_ADDR, 32'h0000_0001);
        idle_total <= 3'b000;
        bus_write(STATUS_ADDR, 32'h0000_0001);
    endtask

    task rise(input logic [2:0] p);
        @(posedge hclk);
        volt_rise_evt <= p;
        @(posedge hclk);
        volt_rise_evt <= 3'b000;
    endtask

    // A then B is the good order; A then C is the error
    task t_order;
        bus_write(MASK_ADDR, 32'h0008_0000);
        rise(3'b001);
        rise(3'b010);
        settle(3);
        chk_bit("order good", 1'b0, irq);
        rise(3'b001);
        rise(3'b100);
        settle(3);
        chk_bit("order error irq", 1'b1, irq);
        check_reg("order status", STATUS_ADDR, 32'h0008_0000);
        bus_write(STATUS_ADDR, 32'h0008_0000);
    endtask

    // Difference equal to the threshold stays quiet; two above fires
    task t_imbal;
        bus_write(THRESH_ADDR, 32'h0000_0005);
        bus_write(MASK_ADDR, 32'h0010_0000);
        phase_current_sum <= 28'h000_0008;
        neutral_current_sample <= 28'hfff_fffd;
        settle(3);
        chk_bit("imbalance at limit", 1'b0, irq);
        phase_current_sum <= 28'h000_000a;
        settle(3);
        chk_bit("imbalance over", 1'b1, irq);
        check_reg("imbalance status", STATUS_ADDR, 32'h0010_0000);
        phase_current_sum <= 28'h000_0000;
        neutral_current_sample <= 28'h000_0000;
        bus_write(STATUS_ADDR, 32'h0010_0000);
    endtask

    // Checksum captured at run, then changed
    task t_checksum;
        bus_write(MASK_ADDR, 32'h0200_0000);
        checksum <= 32'h1234_5678;
        @(posedge hclk);
        run_set <= 1'b1;
        @(posedge hclk);
        run_set <= 1'b0;
        settle(3);
        chk_bit("checksum same", 1'b0, irq);
        checksum <= 32'h1234_5679;
        settle(3);
        chk_bit("checksum changed", 1'b1, irq);
        check_reg("checksum status", STATUS_ADDR, 32'h0200_0000);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------------
    // Ceiling far above the several hundred cycles the scenarios need
    always @(posedge hclk)
    begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 20000)
        begin
            fail_count++;
            end_sim();
        end
    end

    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        chk_bit("hreadyout", 1'b1, hreadyout);
        chk_bit("irq reset", 1'b0, irq);
        t_mask_rw();
        t_events();
        t_rst_done();
        t_phase();
        t_idle();
        t_order();
        t_imbal();
        t_checksum();
        end_sim();
    end
endmodule
